// File: logic/crs_regset.sv
// CPU general-purpose and control register set
`timescale 1ns/100ps

module crs_regset
    import crs_pkg::*;
#(
    parameter logic [CRS_XLEN-1:0] RESET_PC = CRS_RST_PC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [CRS_IDXW-1:0] rd_a_idx,
    output logic [CRS_XLEN-1:0] rd_a_data,
    input wire logic [CRS_IDXW-1:0] rd_b_idx,
    output logic [CRS_XLEN-1:0] rd_b_data,
    input wire logic wr_en,
    input wire logic [CRS_IDXW-1:0] wr_idx,
    input wire logic [CRS_XLEN-1:0] wr_data,
    input wire crs_ctl_t ctl_rd_sel,
    output logic [CRS_XLEN-1:0] ctl_rd_data,
    input wire logic ctl_wr_en,
    input wire crs_ctl_t ctl_wr_sel,
    input wire logic [CRS_XLEN-1:0] ctl_wr_data,
    input wire logic pc_load,
    input wire logic [CRS_XLEN-1:0] pc_next,
    input wire logic flag_we,
    input wire logic [CRS_FLAG_W-1:0] flag_val,
    input wire logic fiq_take,
    input wire logic fiq_return,
    output logic [CRS_XLEN-1:0] prog_counter,
    output logic [CRS_XLEN-1:0] proc_status_word,
    output logic [CRS_XLEN-1:0] active_stack_ptr,
    output logic [CRS_XLEN-1:0] vector_table_base,
    output logic [CRS_XLEN-1:0] fast_irq_target,
    output logic [CRS_XLEN-1:0] saved_prog_counter,
    output logic [CRS_XLEN-1:0] saved_status_word
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (RESET_PC[1:0] != 2'b00) begin : g_bad_reset_pc
        $error("RESET_PC must be word aligned");
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage

    logic [CRS_XLEN-1:0] gpr [1:CRS_NGPR-1];
    logic [CRS_XLEN-1:0] irq_stack_ptr;
    logic [CRS_XLEN-1:0] user_stack_ptr;

    // Register zero has no cell of its own; it is a view onto a stack ptr
    function automatic logic [CRS_XLEN-1:0] read_gpr(
        input logic [CRS_IDXW-1:0] idx
    );
        logic [CRS_XLEN-1:0] val;
        val = CRS_RST_WORD;
        if (idx == CRS_SP_IDX) begin
            val = active_stack_ptr;
        end else begin
            val = gpr[idx];
        end
        return val;
    endfunction

    // Strobe and select come in as arguments so callers see every change
    function automatic logic ctl_hit(input logic en, input crs_ctl_t wsel,
                                     input crs_ctl_t sel);
        return en && (wsel == sel);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode

    wire logic stack_sel_user = proc_status_word[CRS_PSW_U_BIT];
    wire logic sp_write = wr_en && (wr_idx == CRS_SP_IDX);
    wire logic fiq_ret_only = fiq_return && !fiq_take;

    assign active_stack_ptr = stack_sel_user ? user_stack_ptr
                                             : irq_stack_ptr;

    // A direct control write beats a register-zero write to the same ptr
    wire logic [CRS_XLEN-1:0] next_isp =
        ctl_hit(ctl_wr_en, ctl_wr_sel, CRS_CTL_ISP) ? ctl_wr_data :
        (sp_write && !stack_sel_user) ? wr_data : irq_stack_ptr;
    wire logic [CRS_XLEN-1:0] next_usp =
        ctl_hit(ctl_wr_en, ctl_wr_sel, CRS_CTL_USP) ? ctl_wr_data :
        (sp_write && stack_sel_user) ? wr_data : user_stack_ptr;

    // Interrupt entry outranks return, which outranks plain updates
    wire logic [CRS_XLEN-1:0] next_pc =
        fiq_take ? fast_irq_target :
        fiq_return ? saved_prog_counter :
        ctl_hit(ctl_wr_en, ctl_wr_sel, CRS_CTL_PC) ? ctl_wr_data :
        pc_load ? pc_next : prog_counter;

    logic [CRS_XLEN-1:0] flag_merge;
    always_comb begin
        flag_merge = proc_status_word;
        flag_merge[CRS_FLAG_LSB +: CRS_FLAG_W] = flag_val;
    end

    wire logic [CRS_XLEN-1:0] next_psw =
        fiq_take ? proc_status_word :
        fiq_return ? saved_status_word :
        ctl_hit(ctl_wr_en, ctl_wr_sel, CRS_CTL_PSW) ? ctl_wr_data :
        flag_we ? flag_merge : proc_status_word;

    // Backup status word is a straight copy, so every bit keeps its place
    wire logic [CRS_XLEN-1:0] next_saved_status_word =
        fiq_take ? proc_status_word :
        ctl_hit(ctl_wr_en, ctl_wr_sel, CRS_CTL_SAVED_STATUS_WORD) ? ctl_wr_data :
        saved_status_word;
    wire logic [CRS_XLEN-1:0] next_bpc =
        fiq_take ? prog_counter :
        ctl_hit(ctl_wr_en, ctl_wr_sel, CRS_CTL_BPC) ? ctl_wr_data :
        saved_prog_counter;

    logic [CRS_XLEN-1:0] ctl_view;
    always_comb begin
        ctl_view = CRS_RST_WORD;
        unique case (ctl_rd_sel)
            CRS_CTL_ISP: ctl_view = irq_stack_ptr;
            CRS_CTL_USP: ctl_view = user_stack_ptr;
            CRS_CTL_VECTOR_TABLE_BASE: ctl_view = vector_table_base;
            CRS_CTL_PC: ctl_view = prog_counter;
            CRS_CTL_PSW: ctl_view = proc_status_word;
            CRS_CTL_BPC: ctl_view = saved_prog_counter;
            CRS_CTL_SAVED_STATUS_WORD: ctl_view = saved_status_word;
            CRS_CTL_FINT: ctl_view = fast_irq_target;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // General-purpose cells

    for (genvar i = 1; i < CRS_NGPR; i++) begin : g_gpr
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                gpr[i] <= CRS_RST_WORD;
            end else if (ce && wr_en && (wr_idx == CRS_IDXW'(i))) begin
                gpr[i] <= wr_data;
            end
        end
    end

    // Reads are registered: a write shows on the port from the next edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_a_data <= CRS_RST_WORD;
            rd_b_data <= CRS_RST_WORD;
            ctl_rd_data <= CRS_RST_WORD;
        end else if (ce) begin
            rd_a_data <= read_gpr(rd_a_idx);
            rd_b_data <= read_gpr(rd_b_idx);
            ctl_rd_data <= ctl_view;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stack_ptr <= CRS_RST_WORD;
            user_stack_ptr <= CRS_RST_WORD;
            prog_counter <= RESET_PC;
            proc_status_word <= CRS_RST_WORD;
            saved_prog_counter <= CRS_RST_WORD;
            saved_status_word <= CRS_RST_WORD;
        end else if (ce) begin
            irq_stack_ptr <= next_isp;
            user_stack_ptr <= next_usp;
            prog_counter <= next_pc;
            proc_status_word <= next_psw;
            saved_prog_counter <= next_bpc;
            saved_status_word <= next_saved_status_word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_table_base <= CRS_RST_WORD;
            fast_irq_target <= CRS_RST_WORD;
        end else if (ce) begin
            if (ctl_hit(ctl_wr_en, ctl_wr_sel, CRS_CTL_VECTOR_TABLE_BASE)) begin
                vector_table_base <= ctl_wr_data;
            end
            if (ctl_hit(ctl_wr_en, ctl_wr_sel, CRS_CTL_FINT)) begin
                fast_irq_target <= ctl_wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_fiq_entry;
        ce && fiq_take;
    endsequence

    sequence s_gpr_write;
        ce && wr_en && (wr_idx != CRS_SP_IDX);
    endsequence

    sequence s_read_back;
        ce && (rd_a_idx == $past(wr_idx)) &&
            !(wr_en && (wr_idx == rd_a_idx));
    endsequence

    property p_fiq_save_pc;
        s_fiq_entry |=> saved_prog_counter == $past(prog_counter);
    endproperty
    a_fiq_save_pc: assert property (p_fiq_save_pc)
        else $error("backup pc not captured on fast interrupt");

    property p_fiq_save_psw;
        s_fiq_entry |=> (saved_status_word == $past(proc_status_word)) &&
            (saved_status_word[CRS_PSW_U_BIT] ==
             $past(stack_sel_user));
    endproperty
    a_fiq_save_psw: assert property (p_fiq_save_psw)
        else $error("backup status word not captured");

    property p_fiq_branch;
        s_fiq_entry |=> prog_counter == $past(fast_irq_target);
    endproperty
    a_fiq_branch: assert property (p_fiq_branch)
        else $error("fast interrupt did not branch to target");

    property p_fiq_round_trip;
        s_fiq_entry ##1 (ce && fiq_ret_only) |=>
            (prog_counter == $past(prog_counter, 2)) &&
            (proc_status_word == $past(proc_status_word, 2));
    endproperty
    a_fiq_round_trip: assert property (p_fiq_round_trip)
        else $error("fast return did not restore pc and status");

    sequence s_fiq_exit;
        ce && fiq_ret_only;
    endsequence

    property p_fiq_exit;
        s_fiq_exit |=> (prog_counter == $past(saved_prog_counter)) &&
            (proc_status_word == $past(saved_status_word));
    endproperty
    a_fiq_exit: assert property (p_fiq_exit)
        else $error("fast return did not reload from backups");

    property p_gpr_readback;
        s_gpr_write ##1 s_read_back |=>
            rd_a_data == $past(wr_data, 2);
    endproperty
    a_gpr_readback: assert property (p_gpr_readback)
        else $error("general register read back mismatch");

    property p_sp_view;
        ce && (rd_b_idx == CRS_SP_IDX) |=>
            rd_b_data == $past(active_stack_ptr);
    endproperty
    a_sp_view: assert property (p_sp_view)
        else $error("register zero is not the active stack ptr");

    property p_sp_route;
        ce && sp_write && !ctl_wr_en |=>
            (stack_sel_user ? user_stack_ptr : irq_stack_ptr) ==
                $past(wr_data) ||
            ($past(stack_sel_user) != stack_sel_user);
    endproperty
    a_sp_route: assert property (p_sp_route)
        else $error("stack write went to the wrong pointer");

    property p_sp_other_kept;
        ce && sp_write && !ctl_wr_en && !stack_sel_user |=>
            $stable(user_stack_ptr);
    endproperty
    a_sp_other_kept: assert property (p_sp_other_kept)
        else $error("inactive stack ptr was disturbed");

    property p_flags;
        ce && flag_we && !fiq_take && !fiq_return && !ctl_wr_en |=>
            (proc_status_word[CRS_FLAG_LSB +: CRS_FLAG_W] ==
             $past(flag_val)) && $stable(stack_sel_user);
    endproperty
    a_flags: assert property (p_flags)
        else $error("status flags not updated");

    property p_vector_table_base;
        ce && ctl_hit(ctl_wr_en, ctl_wr_sel, CRS_CTL_VECTOR_TABLE_BASE) ##1
            (ce && ctl_rd_sel == CRS_CTL_VECTOR_TABLE_BASE)
            |=> ctl_rd_data == $past(ctl_wr_data, 2);
    endproperty
    a_vector_table_base: assert property (p_vector_table_base)
        else $error("vector table base not held");

    property p_pc_load;
        ce && pc_load && !fiq_take && !fiq_return && !ctl_wr_en |=>
            prog_counter == $past(pc_next);
    endproperty
    a_pc_load: assert property (p_pc_load)
        else $error("program counter not loaded");

    property p_freeze;
        !ce |=> $stable(prog_counter) && $stable(proc_status_word) &&
            $stable(rd_a_data);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

endmodule

// File: logic/crs_pkg.sv
// Constants and types shared by the CPU control register set
package crs_pkg;

    localparam int CRS_XLEN = 32;
    localparam int CRS_NGPR = 16;
    localparam int CRS_IDXW = 4;

    // Status word layout: outcome flags low, stack select above them
    localparam int CRS_FLAG_W = 4;
    localparam int CRS_FLAG_LSB = 0;
    localparam int CRS_PSW_U_BIT = 8;

    localparam logic [CRS_IDXW-1:0] CRS_SP_IDX = 4'h0;
    localparam logic [CRS_XLEN-1:0] CRS_RST_WORD = 32'h0000_0000;
    localparam logic [CRS_XLEN-1:0] CRS_RST_PC = 32'h0000_0000;

    typedef enum logic [2:0] {
        CRS_CTL_ISP,
        CRS_CTL_USP,
        CRS_CTL_VECTOR_TABLE_BASE,
        CRS_CTL_PC,
        CRS_CTL_PSW,
        CRS_CTL_BPC,
        CRS_CTL_SAVED_STATUS_WORD,
        CRS_CTL_FINT
    } crs_ctl_t;

endpackage

// File: verif/crs_pipe_model.sv
// Pipeline model that issues requests into the register set
`timescale 1ns/100ps

module crs_pipe_model
    import crs_pkg::*;
(
    input wire logic clk,
    output logic ce,
    output logic wr_en,
    output logic [CRS_IDXW-1:0] rd_a_idx,
    output logic [CRS_IDXW-1:0] rd_b_idx,
    output logic [CRS_IDXW-1:0] wr_idx,
    output logic [CRS_XLEN-1:0] wr_data,
    output crs_ctl_t ctl_rd_sel,
    output crs_ctl_t ctl_wr_sel,
    output logic ctl_wr_en,
    output logic [CRS_XLEN-1:0] ctl_wr_data,
    output logic pc_load,
    output logic [CRS_XLEN-1:0] pc_next,
    output logic flag_we,
    output logic [CRS_FLAG_W-1:0] flag_val,
    output logic fiq_take,
    output logic fiq_return,
    output logic look
);
    initial begin
        {ce, wr_en, ctl_wr_en, pc_load, flag_we} = 5'h10;
        {fiq_take, fiq_return, look} = '0;
        {rd_a_idx, rd_b_idx, wr_idx, flag_val} = '0;
        {wr_data, ctl_wr_data, pc_next} = '0;
        ctl_rd_sel = CRS_CTL_ISP;
        ctl_wr_sel = CRS_CTL_ISP;
    end

    // One request per call, two for kind 10; taken on the next edge unless kind 9 drops ce, then released
    task automatic op(input int k, input logic [3:0] ix,
                      input logic [CRS_XLEN-1:0] d);
        @(posedge clk);
        case (k)
            0, 9: begin
                ce <= (k == 0);
                wr_en <= 1'b1;
                wr_idx <= ix;
                wr_data <= d;
            end
            1: begin
                ctl_wr_en <= 1'b1;
                ctl_wr_sel <= crs_ctl_t'(ix[2:0]);
                ctl_wr_data <= d;
            end
            2: begin
                pc_load <= 1'b1;
                pc_next <= d;
            end
            3: begin
                flag_we <= 1'b1;
                flag_val <= d[CRS_FLAG_W-1:0];
            end
            4, 10: fiq_take <= 1'b1;
            5: fiq_return <= 1'b1;
            6: rd_a_idx <= ix;
            7: rd_b_idx <= ix;
            default: ctl_rd_sel <= crs_ctl_t'(ix[2:0]);
        endcase
        look <= (k > 5 && k < 9);
        @(posedge clk);
        // Kind 10 follows the entry with a return on the very next cycle
        if (k == 10) begin
            fiq_take <= 1'b0;
            fiq_return <= 1'b1;
            @(posedge clk);
        end
        {wr_en, ctl_wr_en, pc_load, flag_we} <= '0;
        {fiq_take, fiq_return, look} <= '0;
        ce <= 1'b1;
        // Idle data lines must not keep showing the last value
        wr_data <= ~wr_data;
        ctl_wr_data <= ~ctl_wr_data;
        pc_next <= ~pc_next;
    endtask
endmodule

// File: verif/crs_regset_tb.sv
// Self-checking bench for the CPU control register set
`timescale 1ns/100ps

module crs_regset_tb;
    import crs_pkg::*;
    logic clk, rst_n, ce, wr_en, ctl_wr_en, pc_load, flag_we;
    logic fiq_take, fiq_return, look, lk1;
    logic [CRS_IDXW-1:0] rd_a_idx, rd_b_idx, wr_idx;
    logic [CRS_FLAG_W-1:0] flag_val;
    logic [CRS_XLEN-1:0] wr_data, ctl_wr_data, pc_next, d;
    logic [CRS_XLEN-1:0] rd_a_data, rd_b_data, ctl_rd_data;
    logic [CRS_XLEN-1:0] prog_counter, proc_status_word, active_stack_ptr;
    logic [CRS_XLEN-1:0] vector_table_base, fast_irq_target, w;
    logic [CRS_XLEN-1:0] saved_prog_counter, saved_status_word;
    logic [CRS_XLEN-1:0] mg [CRS_NGPR];
    logic [CRS_XLEN-1:0] mc [8];
    logic [CRS_XLEN+1:0] exq [$];
    logic [CRS_XLEN+1:0] x;
    crs_ctl_t ctl_rd_sel, ctl_wr_sel;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    crs_regset i_crs_regset (
        .clk(clk), .rst_n(rst_n), .ce(ce), .rd_a_idx(rd_a_idx),
        .rd_a_data(rd_a_data), .rd_b_idx(rd_b_idx), .rd_b_data(rd_b_data),
        .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
        .ctl_rd_sel(ctl_rd_sel), .ctl_rd_data(ctl_rd_data),
        .ctl_wr_en(ctl_wr_en), .ctl_wr_sel(ctl_wr_sel),
        .ctl_wr_data(ctl_wr_data), .pc_load(pc_load), .pc_next(pc_next),
        .flag_we(flag_we), .flag_val(flag_val), .fiq_take(fiq_take),
        .fiq_return(fiq_return), .prog_counter(prog_counter),
        .proc_status_word(proc_status_word),
        .active_stack_ptr(active_stack_ptr),
        .vector_table_base(vector_table_base),
        .fast_irq_target(fast_irq_target),
        .saved_prog_counter(saved_prog_counter),
        .saved_status_word(saved_status_word)
    );

    crs_pipe_model i_crs_pipe_model (
        .clk(clk), .ce(ce), .wr_en(wr_en), .rd_a_idx(rd_a_idx),
        .rd_b_idx(rd_b_idx), .wr_idx(wr_idx), .wr_data(wr_data),
        .ctl_rd_sel(ctl_rd_sel), .ctl_wr_sel(ctl_wr_sel),
        .ctl_wr_en(ctl_wr_en), .ctl_wr_data(ctl_wr_data),
        .pc_load(pc_load), .pc_next(pc_next), .flag_we(flag_we),
        .flag_val(flag_val), .fiq_take(fiq_take),
        .fiq_return(fiq_return), .look(look)
    );

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [CRS_XLEN-1:0] g,
                       input logic [CRS_XLEN-1:0] w);
        samples_checked++;
        if (g !== w) begin
            n_mismatch++;
            $display("ERROR %0t: read %h expected %h", $time, g, w);
        end
    endtask

    task automatic chk_out(input logic [CRS_XLEN-1:0] g,
                           input logic [CRS_XLEN-1:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t: output %h expected %h", $time, g, e);
        end
    endtask

    task automatic op(input int k, input int ix, input logic [31:0] v);
        i_crs_pipe_model.op(k, ix[3:0], v);
    endtask

    // Note the expected word first; the watcher pops it when data lands
    task automatic rd(input int k, input int ix, input logic [31:0] w);
        exq.push_back({2'(k - 6), w});
        op(k, ix, w);
    endtask

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk) lk1 <= look;

    always @(negedge clk) begin
        if (lk1 === 1'b1) begin
            x = exq.pop_front();
            case (x[CRS_XLEN+1:CRS_XLEN])
                2'h0: chk(rd_a_data, x[CRS_XLEN-1:0]);
                2'h1: chk(rd_b_data, x[CRS_XLEN-1:0]);
                default: chk(ctl_rd_data, x[CRS_XLEN-1:0]);
            endcase
            // Nothing moves during a read, so the direct outputs agree
            w = x[CRS_XLEN-1:0];
            if (x[CRS_XLEN+1] === 1'b1) begin
                case (ctl_rd_sel)
                    CRS_CTL_VECTOR_TABLE_BASE: chk_out(vector_table_base, w);
                    CRS_CTL_PC: chk_out(prog_counter, w);
                    CRS_CTL_PSW: chk_out(proc_status_word, w);
                    CRS_CTL_BPC: chk_out(saved_prog_counter, w);
                    CRS_CTL_SAVED_STATUS_WORD: chk_out(saved_status_word, w);
                    CRS_CTL_FINT: chk_out(fast_irq_target, w);
                    default: ;
                endcase
            end else if (!x[CRS_XLEN] && rd_a_idx == CRS_SP_IDX) begin
                chk_out(active_stack_ptr, w);
            end
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        for (int i = 0; i < 8; i++) mc[i] = '0;
        d = $urandom(71281);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(8, i, mc[i]);
        for (int i = 1; i < CRS_NGPR; i++) begin
            mg[i] = $urandom;
            op(0, i, mg[i]);
        end
        for (int i = 1; i < CRS_NGPR; i++) begin
            rd(6, i, mg[i]);
            rd(7, CRS_NGPR - i, mg[CRS_NGPR - i]);
        end
        for (int i = 0; i < 8; i++) begin
            mc[i] = $urandom;
            if (i < 2) mc[i][1:0] = 2'h0;
            op(1, i, mc[i]);
        end
        for (int i = 0; i < 8; i++) rd(8, i, mc[i]);
        // Rewrite the table base while its read select is already up
        rd(8, 2, mc[2]);
        mc[2] = $urandom;
        op(1, 2, mc[2]);
        rd(8, 2, mc[2]);
        // R0 follows the stack select bit; the other pointer is kept
        for (int u = 0; u < 2; u++) begin
            mc[4] = 32'h0000_0000;
            mc[4][CRS_PSW_U_BIT] = u[0];
            op(1, 4, mc[4]);
            mc[u] = $urandom & 32'hFFFF_FFFC;
            op(0, 0, mc[u]);
            rd(6, 0, mc[u]);
            rd(8, 1 - u, mc[1 - u]);
        end
        op(9, 5, ~mg[5]);
        rd(6, 5, mg[5]);
        // Write the register whose index the read port already holds
        mg[5] = $urandom;
        op(0, 5, mg[5]);
        rd(6, 5, mg[5]);
        d = $urandom;
        mc[4][3:0] = d[3:0];
        op(3, 0, d);
        rd(8, 4, mc[4]);
        mc[3] = $urandom;
        op(2, 0, mc[3]);
        rd(8, 3, mc[3]);
        mc[5] = mc[3];
        mc[6] = mc[4];
        mc[3] = mc[7];
        op(4, 0, '0);
        for (int i = 3; i < 7; i++) begin
            rd(8, i, mc[i]);
        end
        // Flags disturbed inside the handler must come back on return
        op(3, 0, ~d);
        mc[3] = mc[5];
        mc[4] = mc[6];
        op(5, 0, '0);
        rd(8, 3, mc[3]);
        rd(8, 4, mc[4]);
        // Entry and return on back-to-back cycles end where they began
        mc[5] = mc[3];
        op(10, 0, '0);
        for (int i = 3; i < 7; i++) rd(8, i, mc[i]);
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule
